// File: include/touch_cmd_pkg.sv
// constants of the touch-key supervisory command interpreter
package touch_cmd_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_NEG_BAND = 8'h0F;
  localparam logic [7:0] CMD_NEIGHBOUR = 8'h10;
  localparam logic [7:0] CMD_CHECKSUM = 8'h36;
  localparam logic [7:0] CMD_CONV_TEST = 8'h44;
  localparam logic [7:0] CMD_REF_LOCK = 8'h4C;
  localparam logic [7:0] CMD_VERSION = 8'h56;
  localparam logic [7:0] CMD_SIZE_CODE = 8'h57;
  localparam logic [7:0] CMD_SLEEP = 8'h5A;
  localparam logic [7:0] CMD_RECAL = 8'h62;
  localparam logic [7:0] CMD_LAST = 8'h6C;
  localparam logic [7:0] CMD_RESET = 8'h72;
  localparam logic [7:0] NULL_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // field values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] NEG_BAND_MAX = 8'h63;
  localparam logic [6:0] NEG_BAND_RST = 7'h00;
  localparam logic [7:0] NEIGHBOUR_ON = 8'h01;
  localparam logic [7:0] CONV_RST = 8'h00;
  localparam logic [7:0] VERSION_DEF = 8'h5C;
  localparam logic [7:0] SIZE_CODE_DEF = 8'hA5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 125000000;
  localparam longint CLK_NS = 8;
  localparam longint PARAM_WAIT_MS = 100;
  localparam longint RESET_DELAY_MS = 16;
  localparam longint RESET_GUARD_S = 2;
  localparam longint WAKE_LOW_NS = 10000;
  localparam int PARAM_WAIT_CYC = int'(PARAM_WAIT_MS * CLK_HZ / 1000);
  localparam int RESET_DELAY_CYC = int'(RESET_DELAY_MS * CLK_HZ / 1000);
  localparam int RESET_GUARD_CYC = int'(RESET_GUARD_S * CLK_HZ);
  localparam int WAKE_LOW_CYC = int'((WAKE_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam int TMR_W = 28;
  localparam int WAKE_W = 11;

  // ----------------------------------------------------------------
  // sequencer states, gray in declaration order
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PARAM = 3'h1,
    ST_LOCK_WR = 3'h3,
    ST_RST_ECHO = 3'h2,
    ST_RST_DLY = 3'h6,
    ST_SLP_ECHO = 3'h7,
    ST_SLEEP = 3'h5
  } seq_state_t;

endpackage : touch_cmd_pkg

// File: hw/touch_cmd_core.sv
// supervisory command interpreter of a matrix touch-key controller
//
// Behaviour
// R1: put-mode negative band command stores one global band for all keys.
// R2: negative band accepts 0..99; larger values clamp to 99.
// R3: band value is a direct percentage of the locked signal level.
// R4: band of zero disables the negative reference error check.
// R5: get-mode negative band command returns the stored setting.
// R6: code 0x10 put sets neighbour suppression per scoped key, 0 off, 1 on.
// R7: suppression compares only keys that have it enabled.
// R8: keys with zero burst length stay out of suppression.
// R9: supervisory commands ignore key scope unless they define their own.
// R10: code 0x36 get returns the stored-setup checksum byte.
// R11: converter test 0x44 put needs its value within 100ms, else cancelled.
// R12: converter test zeroes all burst lengths and stops scanning.
// R13: converter test stops sensing until reset; repeats update the output.
// R14: reference lock 0x4C put, all keys, needs 0x00 within 100ms.
// R15: reference lock writes nonvolatile storage; echo waits until done.
// R16: code 0x62 put starts recalibration of scoped keys, echoes at once.
// R17: recalibration during recalibration restarts the affected keys.
// R18: code 0x6C returns previous command byte; repeats then return 0x6C.
// R19: reset 0x72 put needs null within 100ms; echo then reset after 16ms.
// R20: if reset echo cannot leave, reset anyway after about two seconds.
// R21: code 0x56 get returns the version byte; no put form.
// R22: code 0x57 get returns the size code byte; no put form.
// R23: sleep 0x5A put needs null within 100ms; echo before and after sleep.
`timescale 1ns/1ps

module touch_cmd_core #(
  parameter int KEYS = 64,
  parameter int KEY_IDX_W = 6,
  parameter logic [7:0] VERSION = touch_cmd_pkg::VERSION_DEF, // arbitrary value
  parameter logic [7:0] SIZE_CODE = touch_cmd_pkg::SIZE_CODE_DEF, // arbitrary value
  parameter int PARAM_WAIT_CYC = touch_cmd_pkg::PARAM_WAIT_CYC,
  parameter int RESET_DELAY_CYC = touch_cmd_pkg::RESET_DELAY_CYC,
  parameter int RESET_GUARD_CYC = touch_cmd_pkg::RESET_GUARD_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic link_clk_i,
  input wire logic link_sel_n_i,
  input wire logic link_mosi_i,
  output logic link_miso_o,
  input wire logic put_mode_i,
  input wire logic [KEYS-1:0] scope_mask_i,
  input wire logic [KEY_IDX_W-1:0] key_index_i,
  input wire logic [KEYS-1:0] burst_nonzero_i,
  input wire logic [7:0] checksum_i,
  input wire logic nv_done_i,
  input wire logic wake_n_i,
  output logic [6:0] neg_band_pct_o,
  output logic neg_check_en_o,
  output logic [KEYS-1:0] neighbour_pool_o,
  output logic conv_test_o,
  output logic [7:0] conv_value_o,
  output logic burst_zero_o,
  output logic nv_lock_req_o,
  output logic recal_req_o,
  output logic [KEYS-1:0] recal_mask_o,
  output logic soft_reset_o,
  output logic sleep_o,
  output logic force_get_o
);

  // ----------------------------------------------------------------
  // link side, clocked by the host's serial clock
  // ----------------------------------------------------------------
  logic frame_rst;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_shift_q;
  logic [7:0] rx_byte_q;
  logic rx_tgl_q;
  logic [7:0] tx_shift_q;
  logic [1:0] tx_req_sync_q;
  logic tx_seen_q;
  logic sending_q;
  logic tx_done_tgl_q;
  logic [7:0] tx_byte_q;
  logic tx_tgl_q;

  // bit position restarts with every frame, so a stray edge cannot skew bytes
  assign frame_rst = reset_i | link_sel_n_i;

  always_ff @(posedge link_clk_i or posedge frame_rst)
  begin
    if (frame_rst)
      bit_cnt_q <= 3'h0;
    else
      bit_cnt_q <= bit_cnt_q + 3'h1;
  end

  // receive msb first; whole byte handed over with a toggle
  always_ff @(posedge link_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_shift_q <= 7'h00;
      rx_byte_q <= 8'h00;
      rx_tgl_q <= 1'b0;
    end
    else if (!link_sel_n_i)
    begin
      rx_shift_q <= {rx_shift_q[5:0], link_mosi_i};
      if (bit_cnt_q == 3'h7)
      begin
        rx_byte_q <= {rx_shift_q, link_mosi_i};
        rx_tgl_q <= ~rx_tgl_q;
      end
    end
  end

  // answer request toggle, two flops
  always_ff @(posedge link_clk_i or posedge reset_i)
  begin
    if (reset_i)
      tx_req_sync_q <= 2'h0;
    else
      tx_req_sync_q <= {tx_req_sync_q[0], tx_tgl_q};
  end

  // answer loaded at a byte boundary; core holds it stable
  always_ff @(posedge link_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tx_shift_q <= 8'h00;
      link_miso_o <= 1'b0;
      tx_seen_q <= 1'b0;
      sending_q <= 1'b0;
      tx_done_tgl_q <= 1'b0;
    end
    else if (!link_sel_n_i)
    begin
      if (bit_cnt_q == 3'h0)
      begin
        sending_q <= tx_seen_q != tx_req_sync_q[1];
        tx_seen_q <= tx_req_sync_q[1];
        if (tx_seen_q != tx_req_sync_q[1])
        begin
          link_miso_o <= tx_byte_q[7];
          tx_shift_q <= {tx_byte_q[6:0], 1'b0};
        end
        else
        begin
          link_miso_o <= 1'b0;
          tx_shift_q <= 8'h00;
        end
      end
      else
      begin
        link_miso_o <= tx_shift_q[7];
        tx_shift_q <= {tx_shift_q[6:0], 1'b0};
        if (bit_cnt_q == 3'h7 && sending_q)
          tx_done_tgl_q <= ~tx_done_tgl_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // crossings into the core clock
  // ----------------------------------------------------------------
  logic [2:0] rx_sync_q;
  logic [2:0] txd_sync_q;
  logic [1:0] wake_sync_q;
  logic rx_new;
  logic tx_sent;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_sync_q <= 3'h0;
      txd_sync_q <= 3'h0;
      wake_sync_q <= 2'h3;
    end
    else
    begin
      rx_sync_q <= {rx_sync_q[1:0], rx_tgl_q};
      txd_sync_q <= {txd_sync_q[1:0], tx_done_tgl_q};
      wake_sync_q <= {wake_sync_q[0], wake_n_i};
    end
  end

  // byte stands a whole byte time after its toggle
  assign rx_new = rx_sync_q[2] ^ rx_sync_q[1];
  assign tx_sent = txd_sync_q[2] ^ txd_sync_q[1];

  // ----------------------------------------------------------------
  // wake filter: low long enough
  // ----------------------------------------------------------------
  logic [touch_cmd_pkg::WAKE_W-1:0] wake_cnt_q;
  logic wake_seen;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      wake_cnt_q <= '0;
    else if (!sleep_o || wake_sync_q[1])
      wake_cnt_q <= '0;
    else if (!wake_seen)
      wake_cnt_q <= wake_cnt_q + 1'b1;
  end

  assign wake_seen = wake_cnt_q == touch_cmd_pkg::WAKE_W'(touch_cmd_pkg::WAKE_LOW_CYC);

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  touch_cmd_pkg::seq_state_t state_q;
  logic [touch_cmd_pkg::TMR_W-1:0] tmr_q;
  logic [7:0] cmd_q;
  logic [7:0] last_cmd_q;
  logic [KEYS-1:0] nb_en_q;
  logic param_take;

  assign param_take = (state_q == touch_cmd_pkg::ST_PARAM) && rx_new;

  // R9 scope only reaches the per-key commands
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q <= touch_cmd_pkg::ST_IDLE;
      tmr_q <= '0;
      cmd_q <= 8'h00;
      tx_byte_q <= 8'h00;
      tx_tgl_q <= 1'b0;
      nv_lock_req_o <= 1'b0;
      recal_req_o <= 1'b0;
      recal_mask_o <= '0;
      soft_reset_o <= 1'b0;
      sleep_o <= 1'b0;
      force_get_o <= 1'b0;
    end
    else
    begin
      recal_req_o <= 1'b0;
      force_get_o <= 1'b0;
      soft_reset_o <= 1'b0;
      tmr_q <= tmr_q + 1'b1;
      unique case (state_q)
        touch_cmd_pkg::ST_IDLE:
        begin
          tmr_q <= '0;
          if (rx_new)
          begin
            cmd_q <= rx_byte_q;
            unique case (rx_byte_q)
              touch_cmd_pkg::CMD_NEG_BAND:
              begin
                if (put_mode_i)
                  state_q <= touch_cmd_pkg::ST_PARAM;
                else
                begin
                  // R5 band readback
                  tx_byte_q <= {1'b0, neg_band_pct_o};
                  tx_tgl_q <= ~tx_tgl_q;
                end
              end
              touch_cmd_pkg::CMD_NEIGHBOUR:
              begin
                if (put_mode_i)
                  state_q <= touch_cmd_pkg::ST_PARAM;
                else
                begin
                  tx_byte_q <= {7'h00, nb_en_q[key_index_i]};
                  tx_tgl_q <= ~tx_tgl_q;
                end
              end
              touch_cmd_pkg::CMD_CONV_TEST, touch_cmd_pkg::CMD_REF_LOCK,
              touch_cmd_pkg::CMD_RESET, touch_cmd_pkg::CMD_SLEEP:
              begin
                if (put_mode_i)
                  state_q <= touch_cmd_pkg::ST_PARAM;
              end
              touch_cmd_pkg::CMD_RECAL:
              begin
                // R16 start and echo at once
                // R17 restart is a fresh request on busy keys too
                if (put_mode_i)
                begin
                  recal_req_o <= 1'b1;
                  recal_mask_o <= scope_mask_i;
                  tx_byte_q <= touch_cmd_pkg::CMD_RECAL;
                  tx_tgl_q <= ~tx_tgl_q;
                end
              end
              touch_cmd_pkg::CMD_CHECKSUM, touch_cmd_pkg::CMD_LAST,
              touch_cmd_pkg::CMD_VERSION, touch_cmd_pkg::CMD_SIZE_CODE:
              begin
                // R10 R18 R21 R22 read-only answers
                if (!put_mode_i)
                begin
                  tx_tgl_q <= ~tx_tgl_q;
                  if (rx_byte_q == touch_cmd_pkg::CMD_CHECKSUM)
                    tx_byte_q <= checksum_i;
                  else if (rx_byte_q == touch_cmd_pkg::CMD_LAST)
                    tx_byte_q <= last_cmd_q;
                  else if (rx_byte_q == touch_cmd_pkg::CMD_VERSION)
                    tx_byte_q <= VERSION;
                  else
                    tx_byte_q <= SIZE_CODE;
                end
              end
              default:
                state_q <= touch_cmd_pkg::ST_IDLE; // unknown codes get no answer
            endcase
          end
        end
        touch_cmd_pkg::ST_PARAM:
        begin
          if (rx_new)
          begin
            state_q <= touch_cmd_pkg::ST_IDLE;
            tmr_q <= '0;
            if (cmd_q == touch_cmd_pkg::CMD_REF_LOCK)
            begin
              // R14 only a null completes the lock
              if (rx_byte_q == touch_cmd_pkg::NULL_BYTE)
              begin
                nv_lock_req_o <= 1'b1;
                state_q <= touch_cmd_pkg::ST_LOCK_WR;
              end
            end
            else if (cmd_q == touch_cmd_pkg::CMD_RESET || cmd_q == touch_cmd_pkg::CMD_SLEEP)
            begin
              // R19 R23 null then echo
              if (rx_byte_q == touch_cmd_pkg::NULL_BYTE)
              begin
                tx_byte_q <= cmd_q;
                tx_tgl_q <= ~tx_tgl_q;
                state_q <= (cmd_q == touch_cmd_pkg::CMD_RESET) ?
                           touch_cmd_pkg::ST_RST_ECHO : touch_cmd_pkg::ST_SLP_ECHO;
              end
            end
            else
            begin
              tx_byte_q <= cmd_q;
              tx_tgl_q <= ~tx_tgl_q;
            end
          end
          // R11 R14 R19 R23 parameter window
          else if (tmr_q == touch_cmd_pkg::TMR_W'(PARAM_WAIT_CYC - 1))
            state_q <= touch_cmd_pkg::ST_IDLE;
        end
        touch_cmd_pkg::ST_LOCK_WR:
        begin
          // R15 echo after storage
          if (nv_done_i)
          begin
            nv_lock_req_o <= 1'b0;
            tx_byte_q <= touch_cmd_pkg::CMD_REF_LOCK;
            tx_tgl_q <= ~tx_tgl_q;
            state_q <= touch_cmd_pkg::ST_IDLE;
          end
        end
        touch_cmd_pkg::ST_RST_ECHO, touch_cmd_pkg::ST_SLP_ECHO:
        begin
          if (tx_sent)
          begin
            tmr_q <= '0;
            if (state_q == touch_cmd_pkg::ST_RST_ECHO)
              state_q <= touch_cmd_pkg::ST_RST_DLY;
            else
            begin
              sleep_o <= 1'b1;
              state_q <= touch_cmd_pkg::ST_SLEEP;
            end
          end
          // R20 echo stuck, reset anyway
          else if (tmr_q == touch_cmd_pkg::TMR_W'(RESET_GUARD_CYC - 1))
          begin
            soft_reset_o <= 1'b1;
            state_q <= touch_cmd_pkg::ST_IDLE;
          end
        end
        touch_cmd_pkg::ST_RST_DLY:
        begin
          // R19 soft reset pulse after the echo delay
          if (tmr_q == touch_cmd_pkg::TMR_W'(RESET_DELAY_CYC - 1))
          begin
            soft_reset_o <= 1'b1;
            state_q <= touch_cmd_pkg::ST_IDLE;
          end
        end
        touch_cmd_pkg::ST_SLEEP:
        begin
          // R23 echo again on waking
          if (wake_seen)
          begin
            sleep_o <= 1'b0;
            force_get_o <= 1'b1;
            tx_byte_q <= touch_cmd_pkg::CMD_SLEEP;
            tx_tgl_q <= ~tx_tgl_q;
            state_q <= touch_cmd_pkg::ST_IDLE;
          end
        end
        default:
          state_q <= touch_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  // R18 every command byte, valid or not, becomes the last one
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      last_cmd_q <= 8'h00;
    else if (state_q == touch_cmd_pkg::ST_IDLE && rx_new)
      last_cmd_q <= rx_byte_q;
  end

  // R1 R2 one global band, clamped
  // R3 R4 percentage out, zero turns the check off
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      neg_band_pct_o <= touch_cmd_pkg::NEG_BAND_RST;
      neg_check_en_o <= 1'b0;
    end
    else if (param_take && cmd_q == touch_cmd_pkg::CMD_NEG_BAND)
    begin
      if (rx_byte_q > touch_cmd_pkg::NEG_BAND_MAX)
        neg_band_pct_o <= touch_cmd_pkg::NEG_BAND_MAX[6:0];
      else
        neg_band_pct_o <= rx_byte_q[6:0];
      neg_check_en_o <= rx_byte_q != touch_cmd_pkg::NULL_BYTE;
    end
  end

  // per-key neighbour suppression
  genvar k;
  generate
    for (k = 0; k < KEYS; k++)
    begin : g_key
      // R6 scoped enable, only 0 or 1 accepted
      always_ff @(posedge clk_i or posedge reset_i)
      begin
        if (reset_i)
          nb_en_q[k] <= 1'b0;
        else if (param_take && cmd_q == touch_cmd_pkg::CMD_NEIGHBOUR && scope_mask_i[k]
                 && rx_byte_q <= touch_cmd_pkg::NEIGHBOUR_ON)
          nb_en_q[k] <= rx_byte_q[0];
      end

      // R7 R8 comparison pool: enabled keys with a live burst
      always_ff @(posedge clk_i or posedge reset_i)
      begin
        if (reset_i)
          neighbour_pool_o[k] <= 1'b0;
        else
          neighbour_pool_o[k] <= nb_en_q[k] && burst_nonzero_i[k] && !burst_zero_o;
      end
    end
  endgenerate

  // R12 R13 test mode sticks to reset; repeats set the value
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      conv_test_o <= 1'b0;
      burst_zero_o <= 1'b0;
      conv_value_o <= touch_cmd_pkg::CONV_RST;
    end
    else if (param_take && cmd_q == touch_cmd_pkg::CMD_CONV_TEST)
    begin
      conv_test_o <= 1'b1;
      burst_zero_o <= 1'b1;
      conv_value_o <= rx_byte_q;
    end
  end

endmodule : touch_cmd_core

// File: bench/host_link_model.sv
// host side of the serial command link
`timescale 1ns/1ps

module host_link_model (
  output logic link_clk_o,
  output logic link_sel_n_o,
  output logic link_mosi_o,
  input wire logic link_miso_i
);
  // idle link: clock still, frame closed
  initial
  begin
    link_clk_o = 1'b0;
    link_sel_n_o = 1'b1;
    link_mosi_o = 1'b0;
  end

  // one framed byte, msb first, miso read on falls
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    link_sel_n_o = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      link_mosi_o = tx[i];
      #62.5 link_clk_o = 1'b1;
      #62.5 link_clk_o = 1'b0;
      rx[i] = link_miso_i;
    end
    #62.5 link_sel_n_o = 1'b1;
    // released line shows the inverse
    link_mosi_o = ~tx[0];
  endtask : xfer
endmodule : host_link_model

// File: bench/touch_cmd_assertions.sv
// assertions on the command interpreter ports
`timescale 1ns/1ps

module touch_cmd_assertions #(
  parameter int KEYS = 64
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [KEYS-1:0] burst_nonzero_i,
  input wire logic nv_done_i,
  input wire logic [6:0] neg_band_pct_o,
  input wire logic neg_check_en_o,
  input wire logic [KEYS-1:0] neighbour_pool_o,
  input wire logic conv_test_o,
  input wire logic burst_zero_o,
  input wire logic nv_lock_req_o,
  input wire logic recal_req_o,
  input wire logic soft_reset_o,
  input wire logic sleep_o,
  input wire logic force_get_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // --------
  // band and pool
  // --------
  a_band_in_range: assert property (neg_band_pct_o <= 7'h63)
    else $error("band above limit");
  a_band_zero_off: assert property ($stable(neg_band_pct_o) |->
    neg_check_en_o == (neg_band_pct_o != 7'h00)) else $error("band enable wrong");
  a_pool_burst_only: assert property (
    (neighbour_pool_o & ~$past(burst_nonzero_i)) == '0) else $error("pool has idle key");
  a_pool_frozen: assert property (burst_zero_o |=> neighbour_pool_o == '0)
    else $error("pool active after burst zero");

  // --------
  // supervisory commands
  // --------
  a_zero_first: assert property ($rose(conv_test_o) |-> burst_zero_o)
    else $error("test without burst zero");
  a_test_sticky: assert property (conv_test_o |=> conv_test_o)
    else $error("test mode left");
  a_lock_release: assert property (nv_lock_req_o && nv_done_i |=> !nv_lock_req_o)
    else $error("lock request held");
  a_recal_pulse: assert property (recal_req_o |=> !recal_req_o)
    else $error("recal not a pulse");
  a_reset_pulse: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("reset not a pulse");
  a_wake_get: assert property ($fell(sleep_o) |-> ##[0:2] force_get_o)
    else $error("wake without get");
  c_recal: cover property (recal_req_o);
  c_test: cover property ($rose(conv_test_o));
  c_wake: cover property ($fell(sleep_o));
endmodule : touch_cmd_assertions

bind touch_cmd_core touch_cmd_assertions #(.KEYS(KEYS)) chk_u (
  .clk_i, .reset_i, .burst_nonzero_i, .nv_done_i, .neg_band_pct_o, .neg_check_en_o,
  .neighbour_pool_o, .conv_test_o, .burst_zero_o, .nv_lock_req_o, .recal_req_o,
  .soft_reset_o, .sleep_o, .force_get_o);

// File: bench/testbench.sv
// self-checking bench for the command interpreter
`timescale 1ns/1ps

module testbench;
  localparam logic [7:0] VER = 8'h3A; // arbitrary
  localparam logic [7:0] SZC = 8'h4B; // arbitrary
  localparam int PW = 400;
  localparam int RD = 100;
  localparam int RG = 2000;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic put_mode_i = 1'b0;
  logic [63:0] scope_mask_i = '1;
  logic [63:0] burst_nonzero_i = '1;
  logic [5:0] key_index_i = 6'h00;
  logic [7:0] checksum_i = 8'h00;
  logic nv_done_i = 1'b0;
  logic wake_n_i = 1'b1;
  logic lclk, lsel_n, lmosi, lmiso, band_en, ctest, bzero, lreq, recal, srst, sleep, fget;
  logic [6:0] band;
  logic [63:0] pool, rmask, nb;
  logic [7:0] cval, a, r, v, fill, prev;
  logic [7:0] vals [6];
  integer seed = 32'h012157AB;
  int failures = 0;
  int total_checks = 0;
  int rc = 0;
  int sc = 0;
  int gc = 0;
  int n;

  always #4 clk_i = ~clk_i;

  // count request pulses
  always @(posedge clk_i)
  begin
    rc <= rc + int'(recal);
    sc <= sc + int'(srst);
    gc <= gc + int'(fget);
  end

  touch_cmd_core #(.VERSION(VER), .SIZE_CODE(SZC), .PARAM_WAIT_CYC(PW),
    .RESET_DELAY_CYC(RD), .RESET_GUARD_CYC(RG)) DUT (
    .clk_i, .reset_i, .link_clk_i(lclk), .link_sel_n_i(lsel_n),
    .link_mosi_i(lmosi), .link_miso_o(lmiso), .put_mode_i, .scope_mask_i, .key_index_i,
    .burst_nonzero_i, .checksum_i, .nv_done_i,
    .wake_n_i, .neg_band_pct_o(band), .neg_check_en_o(band_en),
    .neighbour_pool_o(pool), .conv_test_o(ctest), .conv_value_o(cval),
    .burst_zero_o(bzero), .nv_lock_req_o(lreq), .recal_req_o(recal),
    .recal_mask_o(rmask), .soft_reset_o(srst), .sleep_o(sleep), .force_get_o(fget));
  host_link_model host (.link_clk_o(lclk), .link_sel_n_o(lsel_n), .link_mosi_o(lmosi),
    .link_miso_i(lmiso));

  function automatic logic [7:0] band_exp(input logic [7:0] x);
    return (x > 8'h63) ? 8'h63 : x;
  endfunction : band_exp

  function automatic logic [63:0] nb_exp(input logic [63:0] e, m, input logic [7:0] x);
    return (x == 8'h01) ? (e | m) : (x == 8'h00) ? (e & ~m) : e;
  endfunction : nb_exp

  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic gap();
    repeat (4) @(posedge clk_i);
    #1;
  endtask : gap

  task automatic rst();
    reset_i = 1'b1;
    repeat (20) @(posedge clk_i);
    #1 reset_i = 1'b0;
    gap();
  endtask : rst

  // two filler codes, answer in the second
  task automatic fillers(output logic [7:0] ans);
    prev = fill;
    fill = 8'h80 | 8'($random(seed));
    host.xfer(fill, r);
    gap();
    host.xfer(fill, ans);
    gap();
  endtask : fillers

  // command, optional parameter, answer
  task automatic cmd(input logic [7:0] c, input int p, output logic [7:0] ans);
    host.xfer(c, r);
    gap();
    if (p >= 0)
    begin
      host.xfer(8'(p), r);
      gap();
    end
    fillers(ans);
  endtask : cmd

  // bounded poll
  task automatic wait_rst(output int cyc);
    int k;
    k = sc;
    cyc = 0;
    while (sc == k && cyc < 3000)
    begin
      @(posedge clk_i);
      cyc++;
    end
  endtask : wait_rst

  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // hang guard
  initial
  begin
    #640000;
    failures++;
    test_done();
  end

  initial
  begin
    rst();
    vals = '{8'h00, 8'h32, 8'h63, 8'h64, 8'hFF, 8'($random(seed))};
    foreach (vals[i])
    begin
      put_mode_i = 1'b1;
      cmd(touch_cmd_pkg::CMD_NEG_BAND, vals[i], a);
      chk("band_echo", touch_cmd_pkg::CMD_NEG_BAND, a);
      chk("band", band_exp(vals[i]), band);
      chk("band_en", vals[i] != 8'h00, band_en);
      put_mode_i = 1'b0;
      cmd(touch_cmd_pkg::CMD_NEG_BAND, -1, a);
      chk("band_get", band_exp(vals[i]), a);
    end
    $display("band done");
    put_mode_i = 1'b1;
    cmd(touch_cmd_pkg::CMD_NEIGHBOUR, 0, a);
    nb = '0;
    repeat (5)
    begin
      put_mode_i = 1'b1;
      scope_mask_i = {$random(seed), $random(seed)};
      burst_nonzero_i = {$random(seed), $random(seed)};
      v = 8'($random(seed)) & 8'h03;
      cmd(touch_cmd_pkg::CMD_NEIGHBOUR, v, a);
      chk("nb_echo", touch_cmd_pkg::CMD_NEIGHBOUR, a);
      nb = nb_exp(nb, scope_mask_i, v);
      chk("pool", nb & burst_nonzero_i, pool);
      put_mode_i = 1'b0;
      key_index_i = 6'($random(seed));
      cmd(touch_cmd_pkg::CMD_NEIGHBOUR, -1, a);
      chk("nb_get", {7'h00, nb[key_index_i]}, a);
    end
    $display("neighbour done");
    // read-only codes, refused in put mode
    checksum_i = 8'($random(seed));
    for (int m = 0; m < 2; m++)
    begin
      put_mode_i = m[0];
      cmd(touch_cmd_pkg::CMD_CHECKSUM, -1, a);
      chk("checksum", m ? 8'h00 : checksum_i, a);
      cmd(touch_cmd_pkg::CMD_VERSION, -1, a);
      chk("version", m ? 8'h00 : VER, a);
      cmd(touch_cmd_pkg::CMD_SIZE_CODE, -1, a);
      chk("size", m ? 8'h00 : SZC, a);
    end
    put_mode_i = 1'b0;
    cmd(touch_cmd_pkg::CMD_LAST, -1, a);
    chk("last", prev, a);
    $display("read codes done");
    put_mode_i = 1'b1;
    repeat (2)
    begin
      n = rc;
      scope_mask_i = {$random(seed), $random(seed)};
      cmd(touch_cmd_pkg::CMD_RECAL, -1, a);
      chk("recal_echo", touch_cmd_pkg::CMD_RECAL, a);
      chk("recal_cnt", n + 1, rc);
      chk("recal_mask", scope_mask_i, rmask);
    end
    cmd(touch_cmd_pkg::CMD_REF_LOCK, 1, a);
    chk("lock_bad", 9'h000, {lreq, a});
    cmd(touch_cmd_pkg::CMD_REF_LOCK, 0, a);
    chk("lock_busy", 9'h100, {lreq, a});
    repeat (40) @(posedge clk_i);
    #1 nv_done_i = 1'b1;
    @(posedge clk_i);
    #1 nv_done_i = 1'b0;
    gap();
    fillers(a);
    chk("lock_echo", {1'b0, touch_cmd_pkg::CMD_REF_LOCK}, {lreq, a});
    $display("recal lock done");
    // late value cancels, then test mode
    host.xfer(touch_cmd_pkg::CMD_CONV_TEST, r);
    repeat (PW + 100) @(posedge clk_i);
    #1;
    cmd(touch_cmd_pkg::CMD_NEG_BAND, 8'h20, a);
    chk("conv_cancel", {1'b0, touch_cmd_pkg::CMD_NEG_BAND}, {ctest, a});
    repeat (2)
    begin
      v = 8'($random(seed));
      cmd(touch_cmd_pkg::CMD_CONV_TEST, v, a);
      chk("conv", {2'b11, touch_cmd_pkg::CMD_CONV_TEST, v}, {ctest, bzero, a, cval});
      chk("conv_pool", 0, pool);
    end
    rst();
    chk("conv_clear", 2'b00, {ctest, bzero});
    $display("conv test done");
    put_mode_i = 1'b1;
    n = gc;
    cmd(touch_cmd_pkg::CMD_SLEEP, 0, a);
    chk("sleep", {1'b1, touch_cmd_pkg::CMD_SLEEP}, {sleep, a});
    wake_n_i = 1'b0;
    repeat (1300) @(posedge clk_i);
    #1 wake_n_i = 1'b1;
    repeat (3) gap();
    chk("wake", {1'b0, 32'(n + 1)}, {sleep, 32'(gc)});
    put_mode_i = 1'b0;
    fillers(a);
    chk("wake_echo", touch_cmd_pkg::CMD_SLEEP, a);
    $display("sleep done");
    // reset after echo, or by guard
    put_mode_i = 1'b1;
    cmd(touch_cmd_pkg::CMD_RESET, 0, a);
    chk("rst_echo", touch_cmd_pkg::CMD_RESET, a);
    wait_rst(n);
    chk("rst_delay", 1, n > RD - 30 && n <= RD + 5);
    rst();
    put_mode_i = 1'b1;
    host.xfer(touch_cmd_pkg::CMD_RESET, r);
    gap();
    host.xfer(touch_cmd_pkg::NULL_BYTE, r);
    wait_rst(n);
    chk("rst_guard", 1, n > RG - 30 && n <= RG + 5);
    rst();
    $display("reset done");
    test_done();
  end
endmodule : testbench
